// ==== verilog/clk_host_consts.svh ====
// Purpose: Named constants for the dual clock domain host controller.
// Assumes: Device registers are 16 bits wide and addressed by a 16-bit index.
// Notes:   Software register offsets are byte addresses on the AXI4-Lite slave.
`ifndef CLK_HOST_CONSTS_SVH
`define CLK_HOST_CONSTS_SVH

`define DEV_MAIN_CLK_ADDR   16'h0101
`define DEV_MAIN_RATE_ADDR  16'h0102
`define DEV_ASYNC_CLK_ADDR  16'h0112
`define DEV_ASYNC_RATE_ADDR 16'h0113

`define CK_FAMILY_BIT 15
`define CK_FREQ_LSB   8
`define CK_ENA_BIT    6
`define CK_SRC_LSB    0

`define MAIN_FREQ_MAX  3'h6
`define ASYNC_FREQ_MAX 3'h3

`define RATE_NONE      5'h00
`define RATE_48K_LO    5'h01
`define RATE_48K_HI    5'h05
`define RATE_44K_LO    5'h09
`define RATE_44K_HI    5'h0d
`define RATE_LOW_LO    5'h10
`define RATE_LOW_HI    5'h13

`define REG_MAIN_CFG    8'h00
`define REG_MAIN_RATES  8'h04
`define REG_ASYNC_CFG   8'h08
`define REG_ASYNC_RATES 8'h0c
`define REG_PATH        8'h10
`define REG_CMD         8'h14
`define REG_STATUS      8'h18

`define CMD_MAIN_ON   3'h1
`define CMD_MAIN_OFF  3'h2
`define CMD_ASYNC_ON  3'h3
`define CMD_ASYNC_OFF 3'h4
`define CMD_PATH_ON   3'h5

`define ST_STICKY_LSB 8
`define STICKY_W      6

`define MAIN_LAST_STEP  3'h4
`define ASYNC_LAST_STEP 3'h3
`define OFF_LAST_STEP   3'h1

`define AXI_OKAY   2'h0
`define AXI_SLVERR 2'h2

`endif

// ==== verilog/clk_host_pkg.sv ====
// Purpose: Types shared by the dual clock domain host controller.
// Assumes: Constants come from clk_host_consts.svh.
// Notes:   Holds enumerations only.
package clk_host_pkg;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_ISSUE    = 2'b01,
    ST_WRITE    = 2'b10,
    ST_WAIT_OFF = 2'b11
  } seq_state_e;

  typedef enum logic [2:0] {
    SEQ_MAIN_ON   = 3'b001,
    SEQ_MAIN_OFF  = 3'b010,
    SEQ_ASYNC_ON  = 3'b011,
    SEQ_ASYNC_OFF = 3'b100,
    SEQ_PATH_ON   = 3'b101
  } seq_kind_e;

  typedef enum logic [1:0] {
    RC_NONE = 2'b00,
    RC_48K  = 2'b01,
    RC_44K  = 2'b10,
    RC_BAD  = 2'b11
  } rate_class_e;

endpackage

// ==== verilog/regbus_if.sv ====
// Purpose: Register access carrier between the AXI4-Lite slave and the register file.
// Assumes: One write pulse per accepted AXI write; reads are combinational.
// Notes:   Error flags mark unmapped offsets.
`timescale 1ns/1ps
`default_nettype none
interface regbus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input  wr_err, rd_data, rd_err);
  modport regs  (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ==== verilog/axil_regs_slave.sv ====
// Purpose: AXI4-Lite slave front end for the controller registers.
// Assumes: One write and one read outstanding at most.
// Notes:   Write response one cycle after both address and data are held.
`include "clk_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module axil_regs_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  regbus_if.slave          rb
);
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_have_r;
  logic        w_have_r;

  wire aw_hs      = awvalid & awready;
  wire w_hs       = wvalid & wready;
  wire ar_hs      = arvalid & arready;
  wire do_write   = aw_have_r & w_have_r & ~bvalid;
  wire aw_have_nx = (aw_have_r | aw_hs) & ~do_write;
  wire w_have_nx  = (w_have_r | w_hs) & ~do_write;
  wire bvalid_nx  = do_write | (bvalid & ~bready);
  wire rvalid_nx  = ar_hs | (rvalid & ~rready);

  assign rb.wr_en   = do_write;
  assign rb.wr_addr = awaddr_r;
  assign rb.wr_data = wdata_r;
  assign rb.wr_strb = wstrb_r;
  assign rb.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `AXI_OKAY;
    end else begin
      aw_have_r <= aw_have_nx;
      w_have_r  <= w_have_nx;
      // Ready stays low while a beat is held or a response is pending.
      awready   <= ~aw_have_nx & ~bvalid_nx;
      wready    <= ~w_have_nx & ~bvalid_nx;
      bvalid    <= bvalid_nx;
      if (aw_hs) begin
        awaddr_r <= awaddr;
      end
      if (w_hs) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write) begin
        bresp <= rb.wr_err ? `AXI_SLVERR : `AXI_OKAY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `AXI_OKAY;
    end else begin
      arready <= ~rvalid_nx;
      rvalid  <= rvalid_nx;
      if (ar_hs) begin
        rdata <= rb.rd_data;
        rresp <= rb.rd_err ? `AXI_SLVERR : `AXI_OKAY;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/clk_host_ctrl.sv ====
// Purpose: Host side controller that sequences the device's two clock domains.
// Assumes: Device register writes use a req/ack port; GPIO indications are synchronous.
// Notes:   Software orders sequences and polls status.
`include "clk_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clk_host_ctrl #(
  parameter logic [15:0] PATH_DEFAULT = 16'h0000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output var  logic        s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output var  logic        s_axil_wready,
  output var  logic [1:0]  s_axil_bresp,
  output var  logic        s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output var  logic        s_axil_arready,
  output var  logic [31:0] s_axil_rdata,
  output var  logic [1:0]  s_axil_rresp,
  output var  logic        s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output var  logic        dev_wr_req,
  output var  logic [15:0] dev_addr,
  output var  logic [15:0] dev_wdata,
  input  wire logic        dev_wr_ack,
  input  wire logic        main_clock_off_status,
  input  wire logic        async_clock_off_status,
  input  wire logic        main_underclock,
  input  wire logic        async_underclock,
  input  wire logic        clock_error
);
  import clk_host_pkg::*;

  regbus_if rb ();

  axil_regs_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .rb      (rb)
  );

  function automatic rate_class_e rate_class(input logic [4:0] code);
    if (code == `RATE_NONE) begin
      rate_class = RC_NONE;
    end else if ((code >= `RATE_48K_LO && code <= `RATE_48K_HI) ||
                 (code >= `RATE_LOW_LO && code <= `RATE_LOW_HI)) begin
      rate_class = RC_48K;
    end else if (code >= `RATE_44K_LO && code <= `RATE_44K_HI) begin
      rate_class = RC_44K;
    end else begin
      rate_class = RC_BAD;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a <= `REG_STATUS) && (a[1:0] == 2'b00);
  endfunction

  logic [31:0]      main_cfg_r;
  logic [31:0]      main_rates_r;
  logic [31:0]      async_cfg_r;
  logic [31:0]      async_rates_r;
  logic [31:0]      path_r;
  logic [`STICKY_W-1:0] sticky_r;
  seq_state_e       state_r;
  seq_kind_e        kind_r;
  logic [2:0]       step_r;
  logic             main_on_r;
  logic             async_on_r;

  // Register field views.
  wire [2:0]  main_freq   = main_cfg_r[2:0];
  wire        main_family = main_cfg_r[3];
  wire [3:0]  main_src    = main_cfg_r[7:4];
  wire [2:0]  async_freq  = async_cfg_r[2:0];
  wire [3:0]  async_src   = async_cfg_r[7:4];
  wire [4:0]  mrate0      = main_rates_r[4:0];
  wire [4:0]  mrate1      = main_rates_r[12:8];
  wire [4:0]  mrate2      = main_rates_r[20:16];
  wire [4:0]  arate0      = async_rates_r[4:0];
  wire [4:0]  arate1      = async_rates_r[12:8];
  wire [15:0] path_addr   = path_r[15:0];
  wire [15:0] path_on     = path_r[31:16];

  // every main rate must match the declared family.
  wire rate_class_e cm0 = rate_class(mrate0);
  wire rate_class_e cm1 = rate_class(mrate1);
  wire rate_class_e cm2 = rate_class(mrate2);
  wire rate_class_e want_m = main_family ? RC_44K : RC_48K;
  wire main_rates_ok = (cm0 == RC_NONE || cm0 == want_m) &&
                       (cm1 == RC_NONE || cm1 == want_m) &&
                       (cm2 == RC_NONE || cm2 == want_m);
  // code 7 reserved; software picks the highest.
  wire main_cfg_ok = main_rates_ok && (main_freq <= `MAIN_FREQ_MAX);

  // async rates one family; reserved codes rejected.
  wire rate_class_e ca0 = rate_class(arate0);
  wire rate_class_e ca1 = rate_class(arate1);
  wire async_mix = (ca0 == RC_48K && ca1 == RC_44K) || (ca0 == RC_44K && ca1 == RC_48K);
  // only codes 0 to 3 exist for the async domain.
  wire async_cfg_ok = !async_mix && ca0 != RC_BAD && ca1 != RC_BAD &&
                      (async_freq <= `ASYNC_FREQ_MAX);

  // Clock control words; the async word has no family bit.
  function automatic logic [15:0] clk_word(input logic [2:0] freq, input logic fam,
                                           input logic [3:0] src, input logic ena);
    clk_word = 16'h0000;
    clk_word[`CK_FAMILY_BIT] = fam;
    clk_word[`CK_FREQ_LSB +: 3] = freq;
    clk_word[`CK_ENA_BIT] = ena;
    clk_word[`CK_SRC_LSB +: 4] = src;
  endfunction

  // Write list of the running sequence.
  logic [15:0] step_addr;
  logic [15:0] step_data;
  logic        step_last;
  always_comb begin
    step_addr = path_addr;
    step_data = 16'h0000;
    step_last = 1'b1;
    unique case (kind_r)
      SEQ_MAIN_ON: begin
        step_last = (step_r == `MAIN_LAST_STEP);
        // enable raised only in the last write.
        if (step_r == 3'h0 || step_last) begin
          step_addr = `DEV_MAIN_CLK_ADDR;
          step_data = clk_word(main_freq, main_family, main_src, step_last);
        end else begin
          step_addr = `DEV_MAIN_RATE_ADDR + 16'(step_r - 3'h1);
          step_data = {11'h000, main_rates_r[8*(step_r-3'h1) +: 5]};
        end
      end
      SEQ_ASYNC_ON: begin
        step_last = (step_r == `ASYNC_LAST_STEP);
        if (step_r == 3'h0 || step_last) begin
          step_addr = `DEV_ASYNC_CLK_ADDR;
          step_data = clk_word(async_freq, 1'b0, async_src, step_last);
        end else begin
          step_addr = `DEV_ASYNC_RATE_ADDR + 16'(step_r - 3'h1);
          step_data = {11'h000, async_rates_r[8*(step_r-3'h1) +: 5]};
        end
      end
      SEQ_MAIN_OFF, SEQ_ASYNC_OFF: begin
        step_last = (step_r == `OFF_LAST_STEP);
        // path cleared before the enable drops.
        if (step_last) begin
          step_addr = (kind_r == SEQ_MAIN_OFF) ? `DEV_MAIN_CLK_ADDR : `DEV_ASYNC_CLK_ADDR;
          step_data = (kind_r == SEQ_MAIN_OFF) ?
                      clk_word(main_freq, main_family, main_src, 1'b0) :
                      clk_word(async_freq, 1'b0, async_src, 1'b0);
        end
      end
      SEQ_PATH_ON: begin
        // interface clocking goes through this write.
        step_data = path_on;
      end
      default: begin
        step_last = 1'b1;
      end
    endcase
  end

  // Register access decode.
  wire        wr_main   = rb.wr_en && rb.wr_addr == `REG_MAIN_CFG;
  wire        wr_mrates = rb.wr_en && rb.wr_addr == `REG_MAIN_RATES;
  wire        wr_async  = rb.wr_en && rb.wr_addr == `REG_ASYNC_CFG;
  wire        wr_arates = rb.wr_en && rb.wr_addr == `REG_ASYNC_RATES;
  wire        wr_path   = rb.wr_en && rb.wr_addr == `REG_PATH;
  wire        wr_status = rb.wr_en && rb.wr_addr == `REG_STATUS;
  wire        cmd_go    = rb.wr_en && rb.wr_addr == `REG_CMD && rb.wr_strb[0];
  wire [2:0]  cmd_code  = rb.wr_data[2:0];

  wire idle = (state_r == ST_IDLE);
  // paths need main running; async runs only on command.
  wire cmd_ok = idle && (
                (cmd_code == `CMD_MAIN_ON   && main_cfg_ok)  ||
                (cmd_code == `CMD_MAIN_OFF)                  ||
                (cmd_code == `CMD_ASYNC_ON  && async_cfg_ok) ||
                (cmd_code == `CMD_ASYNC_OFF)                 ||
                (cmd_code == `CMD_PATH_ON   && main_on_r));
  wire cmd_start = cmd_go && cmd_ok;

  logic [`STICKY_W-1:0] sticky_set;
  assign sticky_set = {clock_error, async_underclock, main_underclock,
                       state_r == ST_WAIT_OFF && kind_r == SEQ_ASYNC_OFF && async_clock_off_status,
                       state_r == ST_WAIT_OFF && kind_r == SEQ_MAIN_OFF && main_clock_off_status,
                       cmd_go && !cmd_ok};
  wire [`STICKY_W-1:0] sticky_clr = wr_status && rb.wr_strb[1] ?
                                    rb.wr_data[`ST_STICKY_LSB +: `STICKY_W] : '0;

  wire [31:0] status_word = {18'h00000, sticky_r, 3'h0, async_clock_off_status,
                             main_clock_off_status, async_on_r, main_on_r, !idle};
  wire        rd_known = known(rb.rd_addr);
  wire        wr_known = known(rb.wr_addr);
  assign rb.rd_err  = !rd_known;
  assign rb.wr_err  = !wr_known;
  assign rb.rd_data = (rb.rd_addr == `REG_MAIN_CFG)    ? {24'h0, main_cfg_r[7:0]} :
                      (rb.rd_addr == `REG_MAIN_RATES)  ? (main_rates_r & 32'h001f_1f1f) :
                      (rb.rd_addr == `REG_ASYNC_CFG)   ? {24'h0, async_cfg_r[7:0]} :
                      (rb.rd_addr == `REG_ASYNC_RATES) ? (async_rates_r & 32'h0000_1f1f) :
                      (rb.rd_addr == `REG_PATH)        ? path_r :
                      (rb.rd_addr == `REG_STATUS)      ? status_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_cfg_r    <= 32'h0;
      main_rates_r  <= 32'h0;
      async_cfg_r   <= 32'h0;
      async_rates_r <= 32'h0;
      path_r        <= {16'h0, PATH_DEFAULT};
    end else begin
      if (wr_main)   main_cfg_r    <= merge(main_cfg_r, rb.wr_data, rb.wr_strb);
      if (wr_mrates) main_rates_r  <= merge(main_rates_r, rb.wr_data, rb.wr_strb);
      if (wr_async)  async_cfg_r   <= merge(async_cfg_r, rb.wr_data, rb.wr_strb);
      if (wr_arates) async_rates_r <= merge(async_rates_r, rb.wr_data, rb.wr_strb);
      if (wr_path)   path_r        <= merge(path_r, rb.wr_data, rb.wr_strb);
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      kind_r     <= SEQ_MAIN_ON;
      step_r     <= 3'h0;
      dev_wr_req <= 1'b0;
      dev_addr   <= 16'h0000;
      dev_wdata  <= 16'h0000;
      main_on_r  <= 1'b0;
      async_on_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_start) begin
            kind_r  <= seq_kind_e'(cmd_code);
            step_r  <= 3'h0;
            state_r <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          dev_wr_req <= 1'b1;
          dev_addr   <= step_addr;
          dev_wdata  <= step_data;
          state_r    <= ST_WRITE;
        end
        ST_WRITE: begin
          if (dev_wr_ack) begin
            dev_wr_req <= 1'b0;
            step_r     <= step_r + 3'h1;
            state_r    <= ST_ISSUE;
            if (step_last) begin
              state_r <= ST_IDLE;
              if (kind_r == SEQ_MAIN_ON)  main_on_r  <= 1'b1;
              if (kind_r == SEQ_ASYNC_ON) async_on_r <= 1'b1;
              // no writes until shutdown is seen.
              if (kind_r == SEQ_MAIN_OFF || kind_r == SEQ_ASYNC_OFF) begin
                state_r <= ST_WAIT_OFF;
              end
            end
          end
        end
        ST_WAIT_OFF: begin
          // wait for the main shutdown indication.
          if (kind_r == SEQ_MAIN_OFF && main_clock_off_status) begin
            main_on_r <= 1'b0;
            state_r   <= ST_IDLE;
          end
          // same wait for the async domain.
          if (kind_r == SEQ_ASYNC_OFF && async_clock_off_status) begin
            async_on_r <= 1'b0;
            state_r    <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== test/clk_host_monitor.sv ====
// Purpose: Assertions on the device write port of the clock host controller.
// Assumes: Clock word: family bit 15, frequency 10:8, enable bit 6.
// Notes:   Any address outside the clock and rate words is taken as the path register.
`timescale 1ns/1ps
`default_nettype none
module clk_host_monitor (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        dev_wr_req,
  input  wire logic [15:0] dev_addr,
  input  wire logic [15:0] dev_wdata,
  input  wire logic        dev_wr_ack,
  input  wire logic        main_clock_off_status,
  input  wire logic        async_clock_off_status
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] last_r;
  logic        fam_r, up_r, path_r, wm_r, wa_r;
  wire         ack = dev_wr_req && dev_wr_ack;
  wire         mw  = dev_addr == 16'h0101;
  wire         aw  = dev_addr == 16'h0112;
  wire         mr  = dev_addr >= 16'h0102 && dev_addr <= 16'h0104;
  wire         ar  = dev_addr == 16'h0113 || dev_addr == 16'h0114;
  wire         pw  = !(mw || aw || mr || ar);
  wire [4:0]   rc  = dev_wdata[4:0];
  wire         g48 = (rc >= 5'h01 && rc <= 5'h05) || (rc >= 5'h10 && rc <= 5'h13);
  wire         g44 = rc >= 5'h09 && rc <= 5'h0d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_r <= 16'h0000;
      fam_r  <= 1'b0;
      up_r   <= 1'b0;
      path_r <= 1'b0;
      wm_r   <= 1'b0;
      wa_r   <= 1'b0;
    end else begin
      wm_r <= (ack && mw && !dev_wdata[6]) || (wm_r && !main_clock_off_status);
      wa_r <= (ack && aw && !dev_wdata[6]) || (wa_r && !async_clock_off_status);
      if (ack) last_r <= dev_addr;
      if (ack && mw) fam_r <= dev_wdata[15];
      if (ack && mw) up_r <= dev_wdata[6];
      if (ack && pw) path_r <= |dev_wdata;
    end
  end
  AST_REQ_HOLD: assert property (dev_wr_req && !dev_wr_ack |=> dev_wr_req &&
    $stable(dev_addr) && $stable(dev_wdata)) else $error("req moved before ack");
  AST_NO_WR_WAIT: assert property ($rose(dev_wr_req) |-> !wm_r && !wa_r)
    else $error("write during shutdown");
  AST_MAIN_FREQ: assert property (dev_wr_req && mw |-> dev_wdata[10:8] != 3'h7)
    else $error("reserved main freq");
  AST_ASYNC_FREQ: assert property (dev_wr_req && aw |-> dev_wdata[10:8] <= 3'h3
    && !dev_wdata[15]) else $error("bad async word");
  AST_MAIN_RATES: assert property (dev_wr_req && mr |-> rc == 5'h00 || (fam_r ? g44 : g48))
    else $error("main rate family");
  AST_ASYNC_RATES: assert property (dev_wr_req && ar |-> rc == 5'h00 || g44 || g48)
    else $error("reserved async rate");
  AST_PATH_AFTER_CLK: assert property (dev_wr_req && pw && |dev_wdata |-> up_r)
    else $error("path before clock");
  AST_PATH_OFF_FIRST: assert property (ack && mw && !dev_wdata[6] && up_r |-> !path_r)
    else $error("path live at clock off");
  AST_ENA_LAST: assert property (dev_wr_req && (mw || aw) && dev_wdata[6] |->
    last_r == (mw ? 16'h0104 : 16'h0114)) else $error("enable before rates");
  cover property (ack && mw && dev_wdata[6]);
  cover property (ack && aw && dev_wdata[6]);
  cover property ($fell(wm_r));
endmodule
bind clk_host_ctrl clk_host_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .dev_wr_req(dev_wr_req), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_wr_ack(dev_wr_ack), .main_clock_off_status(main_clock_off_status),
  .async_clock_off_status(async_clock_off_status));
`default_nettype wire

// ==== test/dev_model.sv ====
// Purpose: Behavioural device behind the controller's register write port.
// Assumes: One write in flight; ack comes at once or after a random wait.
// Notes:   Shutdown takes seven cycles so the host wait is really exercised.
`timescale 1ns/1ps
`default_nettype none
module dev_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic        dev_wr_req,
  input  wire logic [15:0] dev_addr,
  input  wire logic [15:0] dev_wdata,
  output var  logic        dev_wr_ack,
  output var  logic        main_clock_off_status,
  output var  logic        async_clock_off_status
);
  logic [15:0] regs [0:1023];
  logic [1:0]  wait_r;
  logic [2:0]  mdn_r, adn_r;
  logic        mena_r, aena_r;
  // are internal to the device, not modelled.
  assign main_clock_off_status  = mdn_r == 3'h7;
  assign async_clock_off_status = adn_r == 3'h7;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_wr_ack <= 1'b0;
      wait_r     <= 2'h0;
      mdn_r      <= 3'h7;
      adn_r      <= 3'h7;
      mena_r     <= 1'b0;
      aena_r     <= 1'b0;
    end else begin
      dev_wr_ack <= 1'b0;
      if (dev_wr_req && !dev_wr_ack) begin
        wait_r <= wait_r + 2'h1;
        if (!slow || wait_r == 2'h3) begin
          dev_wr_ack     <= 1'b1;
          wait_r         <= 2'h0;
          regs[dev_addr[9:0]] <= dev_wdata;
          if (dev_addr == 16'h0101) mena_r <= dev_wdata[6];
          if (dev_addr == 16'h0112) aena_r <= dev_wdata[6];
        end
      end
      mdn_r <= mena_r ? 3'h0 : mdn_r + 3'(mdn_r != 3'h7);
      adn_r <= aena_r ? 3'h0 : adn_r + 3'(adn_r != 3'h7);
    end
  end
endmodule
`default_nettype wire

// ==== test/clk_host_ctrl_test.sv ====
// Purpose: Self-checking bench for the clock host controller.
// Assumes: Sequences end when the status busy bit falls.
// Notes:   Random configs come from a fixed seed; refusals are hand-picked.
`timescale 1ns/1ps
`default_nettype none
module clk_host_ctrl_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, fam;
  logic        awready, wready, bvalid, arready, rvalid, req, ack, moff, aoff;
  logic        mund, aund, cerr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, src;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] daddr, dwdata, pv;
  logic [2:0]  fq, u;
  logic [4:0]  r1, r2;
  int          failures, checked, cyc, i;
  clk_host_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .dev_wr_req(req), .dev_addr(daddr), .dev_wdata(dwdata),
    .dev_wr_ack(ack), .main_clock_off_status(moff), .async_clock_off_status(aoff),
    .main_underclock(mund), .async_underclock(aund), .clock_error(cerr));
  dev_model mdl (.aclk(aclk), .aresetn(aresetn), .slow(slow), .dev_wr_req(req),
    .dev_addr(daddr), .dev_wdata(dwdata), .dev_wr_ack(ack),
    .main_clock_off_status(moff), .async_clock_off_status(aoff));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  function automatic logic [15:0] ckw(input logic f, input logic [2:0] q, input logic e,
                                      input logic [3:0] s);
    return {f, 4'h0, q, 1'b0, e, 2'h0, s};
  endfunction
  function automatic logic [4:0] rp(input logic f);
    if (f) return 5'h09 + 5'($urandom % 5);
    return 1'($urandom) ? 5'h01 + 5'($urandom % 5) : 5'h10 + 5'($urandom % 4);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin tw = 1'b1; wvalid <= 1'b0; end
    end while (!(ta && tw));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input logic [2:0] c);
    int n;
    n = 0;
    axw(8'h14, 32'(c), 4'h1);
    do begin axr(8'h18); n++; end while (d[0] !== 1'b0 && n < 400);
    chk(32'(d[0]), 32'h0);
  endtask
  task automatic refuse(input logic [7:0] a1, input logic [31:0] v1, input logic [7:0] a2,
                        input logic [31:0] v2, input logic [2:0] c);
    axw(a1, v1, 4'hf);
    axw(a2, v2, 4'hf);
    run(c);
    chk(32'(d[8]), 32'h1);
    axw(8'h18, 32'h100, 4'h2);
  endtask
  task automatic close_out;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    slow <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 40000) begin failures++; close_out(); end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow, mund, aund, cerr} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {failures, checked, cyc} = '0;
    void'($urandom(32'h3fd1));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(8'h00); chk(d, 32'h0);
    axr(8'h1c); chk(32'(r), 32'h2);
    axw(8'h20, 32'h1, 4'hf); chk(32'(r), 32'h2);
    refuse(8'h00, 32'h7, 8'h04, 32'h0, 3'h1);
    refuse(8'h00, 32'h3, 8'h04, 32'h0b, 3'h1);
    refuse(8'h10, 32'h0001_0300, 8'h04, 32'h0, 3'h5);
    refuse(8'h08, 32'h4, 8'h0c, 32'h0, 3'h3);
    refuse(8'h08, 32'h3, 8'h0c, 32'h0b03, 3'h3);
    for (i = 0; i < 4; i++) begin
      fam = 1'($urandom); src = 4'($urandom); r1 = rp(fam); r2 = rp(fam);
      fq = (i == 0) ? 3'h6 : 3'($urandom % 7);
      axw(8'h00, {24'h0, src, fam, fq}, 4'hf);
      axw(8'h04, {19'h0, r2, 3'h0, r1}, 4'hf);
      run(3'h1);
      chk(32'(mdl.regs[16'h0101]), 32'(ckw(fam, fq, 1'b1, src)));
      chk(32'(mdl.regs[16'h0103][4:0]), 32'(r2));
      pv = 16'($urandom) | 16'h0001;
      axw(8'h10, {pv, 16'h0300}, 4'hf);
      run(3'h5);
      chk(32'(mdl.regs[16'h0300]), 32'(pv));
      run(3'h2);
      chk(32'(mdl.regs[16'h0300]), 32'h0);
      chk(32'({d[9], d[3], d[1]}), 32'h6);
      fq = (i == 0) ? 3'h3 : 3'($urandom % 4); r1 = rp(fam); r2 = rp(fam);
      axw(8'h08, {24'h0, src, 1'b0, fq}, 4'hf);
      axw(8'h0c, {19'h0, r2, 3'h0, r1}, 4'hf);
      run(3'h3);
      chk(32'(mdl.regs[16'h0112]), 32'(ckw(1'b0, fq, 1'b1, src)));
      run(3'h4);
      chk(32'({d[10], d[4], d[2]}), 32'h6);
      axw(8'h18, 32'h3f00, 4'h2);
      u = 3'($urandom % 7) + 3'h1;
      @(posedge aclk);
      {cerr, aund, mund} <= u;
      repeat (3) @(posedge aclk);
      {cerr, aund, mund} <= 3'h0;
      axr(8'h18); chk(32'(d[13:11]), 32'(u));
      axw(8'h18, 32'h3f00, 4'h2);
    end
    close_out();
  end
endmodule
`default_nettype wire
